//--- rcf_pkg.sv
// Register map, field layout and reset values of the regulator block
package rcf_pkg;
  localparam int NBUCK = 4;
  localparam int NLDO = 8;
  localparam int NSRC = 12;
  // Register byte offsets
  localparam logic [7:0] OFS_BUCK_CTRL = 8'h00;
  localparam logic [7:0] OFS_LDO_CTRL = 8'h04;
  localparam logic [7:0] OFS_PG_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_BANK0 = 8'h20;
  localparam logic [7:0] OFS_BANK1 = 8'h30;
  localparam logic [7:0] OFS_LDO_CODE = 8'h40;
  // Field positions
  localparam int BUCK_EN_LSB = 0;
  localparam int BUCK_FIE_LSB = 8;
  localparam int LDO_EN_LSB = 0;
  localparam int LDO_PD_LSB = 8;
  localparam int LDO_FIE_LSB = 16;
  localparam int PG_LDO_LSB = 4;
  // Reset values; the codes stand in for the factory defaults
  localparam logic [3:0] BUCK_EN_RST = 4'hf;
  localparam logic [7:0] LDO_EN_RST = 8'hff;
  localparam logic [5:0] BUCK_CODE_RST = 6'h18;
  localparam logic [5:0] LDO_CODE_RST = 6'h39;
  // Code encoding and analog thresholds, for reference
  localparam int VCODE_ZERO_MV = 600;
  localparam int PG_BUCK_PCT = 7;
  localparam int PG_LDO_PCT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] range;
    logic [2:0] step;
  } rcf_vcode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rcf_wreq_type;
endpackage : rcf_pkg

//--- rcf_top.sv
// Regulator control, power-good and fault interrupt logic behind AXI4-Lite
`timescale 1ns/1ps
module rcf_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  input wire logic [3:0] voltage_bank_pin,
  input wire logic [3:0] buck_pg_in,
  input wire logic [7:0] ldo_pg_in,
  output logic [3:0] buck_on,
  output rcf_pkg::rcf_vcode_type [3:0] buck_code,
  output logic [7:0] ldo_on,
  output rcf_pkg::rcf_vcode_type [7:0] ldo_code,
  output logic [7:0] ldo_discharge,
  output logic fault_irq_n,
  output logic irq
);
  logic [3:0] buck_fie;
  logic [7:0] ldo_pd;
  logic [7:0] ldo_fie;
  rcf_pkg::rcf_vcode_type bank0 [4];
  rcf_pkg::rcf_vcode_type bank1 [4];
  rcf_pkg::rcf_vcode_type ldo_reg [8];
  logic [11:0] irq_status;
  logic [11:0] irq_mask;
  logic [11:0] pend;
  logic [11:0] read_seen;
  logic [11:0] en_all;
  logic [11:0] pg_all;
  logic [11:0] fie_all;
  logic [11:0] fault_now;
  logic [11:0] clr_ok;
  logic [11:0] next_pend;
  logic aw_held;
  logic w_held;
  rcf_pkg::rcf_wreq_type wreq;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_rvalid;
  logic ar_fire;
  logic [31:0] wmask;
  logic [31:0] wword;
  logic [32:0] cur_word;
  logic [32:0] rd_word;
  logic pg_read;

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // Register read view, bit 32 flags a mapped address
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    reg_word = {1'b1, 32'h0};
    if (a == rcf_pkg::OFS_BUCK_CTRL) begin
      reg_word[rcf_pkg::BUCK_EN_LSB +: 4] = buck_on;
      reg_word[rcf_pkg::BUCK_FIE_LSB +: 4] = buck_fie;
    end else if (a == rcf_pkg::OFS_LDO_CTRL) begin
      reg_word[rcf_pkg::LDO_EN_LSB +: 8] = ldo_on;
      reg_word[rcf_pkg::LDO_PD_LSB +: 8] = ldo_pd;
      reg_word[rcf_pkg::LDO_FIE_LSB +: 8] = ldo_fie;
    end else if (a == rcf_pkg::OFS_PG_STAT) begin
      reg_word[11:0] = pg_all;
    end else if (a == rcf_pkg::OFS_IRQ_STAT) begin
      reg_word[11:0] = irq_status;
    end else if (a == rcf_pkg::OFS_IRQ_MASK) begin
      reg_word[11:0] = irq_mask;
    end else if (a[7:4] == rcf_pkg::OFS_BANK0[7:4] && a[1:0] == 2'h0) begin
      reg_word[5:0] = bank0[a[3:2]];
    end else if (a[7:4] == rcf_pkg::OFS_BANK1[7:4] && a[1:0] == 2'h0) begin
      reg_word[5:0] = bank1[a[3:2]];
    end else if (a[7:5] == rcf_pkg::OFS_LDO_CODE[7:5] && a[1:0] == 2'h0) begin
      reg_word[5:0] = ldo_reg[a[4:2]];
    end else begin
      reg_word = 33'h0;
    end
  endfunction : reg_word

  // Flat views of per-regulator state, bucks in the low bits
  assign en_all = {ldo_on, buck_on};
  assign pg_all = {ldo_pg_in, buck_pg_in};
  assign fie_all = {ldo_fie, buck_fie};

  // Write channel holding; address and data are taken in either order
  assign do_write = aw_held && w_held && !s_bvalid;
  assign next_aw_held = (aw_held && !do_write) || (s_awvalid && s_awready);
  assign next_w_held = (w_held && !do_write) || (s_wvalid && s_wready);
  assign wmask = strb_mask(wreq.strb);
  assign wword = (cur_word[31:0] & ~wmask) | (wreq.data & wmask);

  // Views through the decoder; a process so register changes are seen too
  always_comb begin
    cur_word = reg_word(wreq.addr);
    rd_word = reg_word(s_araddr);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      wreq <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_awready <= !next_aw_held;
      s_wready <= !next_w_held;
      if (s_awvalid && s_awready) begin
        wreq.addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        wreq.data <= s_wdata;
        wreq.strb <= s_wstrb;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_bvalid <= 1'b0;
      s_bresp <= rcf_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp <= cur_word[32] ? rcf_pkg::RESP_OKAY : rcf_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Read channel; one read in flight, data captured at address handshake
  assign ar_fire = s_arvalid && s_arready;
  assign next_rvalid = (s_rvalid && !s_rready) || ar_fire;
  assign pg_read = ar_fire && s_araddr == rcf_pkg::OFS_PG_STAT;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= rcf_pkg::RESP_OKAY;
    end else begin
      s_rvalid <= next_rvalid;
      s_arready <= !next_rvalid;
      if (ar_fire) begin
        s_rdata <= rd_word[31:0];
        s_rresp <= rd_word[32] ? rcf_pkg::RESP_OKAY : rcf_pkg::RESP_SLVERR;
      end
    end
  end

  // Control registers; enables and codes start at their defaults
  always_ff @(posedge mclk) begin
    if (rst) begin
      buck_on <= rcf_pkg::BUCK_EN_RST;
      buck_fie <= 4'h0;
      ldo_on <= rcf_pkg::LDO_EN_RST;
      ldo_pd <= 8'h0;
      ldo_fie <= 8'h0;
      irq_mask <= 12'h0;
    end else if (do_write) begin
      if (wreq.addr == rcf_pkg::OFS_BUCK_CTRL) begin
        buck_on <= wword[rcf_pkg::BUCK_EN_LSB +: 4];
        buck_fie <= wword[rcf_pkg::BUCK_FIE_LSB +: 4];
      end
      if (wreq.addr == rcf_pkg::OFS_LDO_CTRL) begin
        ldo_on <= wword[rcf_pkg::LDO_EN_LSB +: 8];
        ldo_pd <= wword[rcf_pkg::LDO_PD_LSB +: 8];
        ldo_fie <= wword[rcf_pkg::LDO_FIE_LSB +: 8];
      end
      if (wreq.addr == rcf_pkg::OFS_IRQ_MASK) begin
        irq_mask <= wword[11:0];
      end
    end
  end

  // Voltage code registers, 6 bits each
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < rcf_pkg::NBUCK; i++) begin
        bank0[i] <= rcf_pkg::BUCK_CODE_RST;
        bank1[i] <= rcf_pkg::BUCK_CODE_RST;
      end
      for (int i = 0; i < rcf_pkg::NLDO; i++) begin
        ldo_reg[i] <= rcf_pkg::LDO_CODE_RST;
      end
    end else if (do_write && cur_word[32]) begin
      if (wreq.addr[7:4] == rcf_pkg::OFS_BANK0[7:4]) begin
        bank0[wreq.addr[3:2]] <= wword[5:0];
      end
      if (wreq.addr[7:4] == rcf_pkg::OFS_BANK1[7:4]) begin
        bank1[wreq.addr[3:2]] <= wword[5:0];
      end
      if (wreq.addr[7:5] == rcf_pkg::OFS_LDO_CODE[7:5]) begin
        ldo_reg[wreq.addr[4:2]] <= wword[5:0];
      end
    end
  end

  // Regulator drive outputs; one cycle behind the pin and the registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      buck_code <= {rcf_pkg::NBUCK{rcf_pkg::BUCK_CODE_RST}};
      ldo_code <= {rcf_pkg::NLDO{rcf_pkg::LDO_CODE_RST}};
      ldo_discharge <= 8'h0;
    end else begin
      for (int i = 0; i < rcf_pkg::NBUCK; i++) begin
        buck_code[i] <= voltage_bank_pin[i] ? bank1[i] : bank0[i];
      end
      for (int i = 0; i < rcf_pkg::NLDO; i++) begin
        ldo_code[i] <= ldo_reg[i];
      end
      // Discharge only while off, one cycle late, so a newly enabled output is still loaded for its first cycle
      ldo_discharge <= ldo_pd & ~ldo_on;
    end
  end

  // Fault latch: set by an enabled regulator with its fault enable set and under threshold, released
  // only once it recovers or is off and the flag has been read
  assign fault_now = fie_all & en_all & ~pg_all;
  assign clr_ok = read_seen & (~en_all | pg_all);
  assign next_pend = fault_now | (pend & ~clr_ok);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend <= 12'h0;
      read_seen <= 12'h0;
      fault_irq_n <= 1'b1;
    end else begin
      pend <= next_pend;
      // A read while still low counts; release waits for recovery or switch-off
      read_seen <= next_pend & (read_seen | {12{pg_read}});
      fault_irq_n <= ~|next_pend;
    end
  end

  // Sticky event status, write one to clear; a new fault wins the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_status <= 12'h0;
      irq <= 1'b0;
    end else begin
      if (do_write && wreq.addr == rcf_pkg::OFS_IRQ_STAT) begin
        irq_status <= (irq_status & ~(wreq.data[11:0] & wmask[11:0]))
                      | (next_pend & ~pend);
      end else begin
        irq_status <= irq_status | (next_pend & ~pend);
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // Checks kept beside the logic
  sequence ctrl_write_s;
    do_write && wreq.addr == rcf_pkg::OFS_BUCK_CTRL && wreq.strb == 4'hf;
  endsequence

  sequence pg_read_s;
    pg_read ##1 (pend != 12'h0);
  endsequence

  bank_select_a: assert property (@(posedge mclk) disable iff (rst)
    voltage_bank_pin[2] |=> buck_code[2] == $past(bank1[2]))
    else $error("buck code not taken from bank 1");

  buck_enable_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl_write_s |=> buck_on == $past(wreq.data[3:0]))
    else $error("buck enable not written");

  pg_readback_a: assert property (@(posedge mclk) disable iff (rst)
    pg_read |=> s_rvalid && s_rdata[11:0] == $past(pg_all))
    else $error("power-good readback wrong");

  fault_assert_a: assert property (@(posedge mclk) disable iff (rst)
    fault_now[3:0] != 4'h0 |=> !fault_irq_n &&
      (pend & $past(fault_now)) == $past(fault_now))
    else $error("fault did not assert the interrupt");

  fault_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !fault_irq_n && read_seen == 12'h0 && !pg_read |=> !fault_irq_n)
    else $error("fault released without a flag read");

  fault_release_a: assert property (@(posedge mclk) disable iff (rst)
    pg_read_s ##0 (fault_now == 12'h0 && (pend & en_all & ~pg_all) == 12'h0)
      [*2] |=> fault_irq_n)
    else $error("fault not released after read and recovery");

  discharge_a: assert property (@(posedge mclk) disable iff (rst)
    ldo_pd != 8'h0 |=> ldo_discharge == ($past(ldo_pd) & ~$past(ldo_on)))
    else $error("discharge path wrong");

  ldo_follow_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(ldo_reg[3]) |=> ldo_code[3] == $past(ldo_reg[3]))
    else $error("ldo code does not follow register");

  reset_default_a: assert property (@(posedge mclk)
    rst |=> buck_code[0] == rcf_pkg::BUCK_CODE_RST && ldo_on ==
      rcf_pkg::LDO_EN_RST)
    else $error("reset defaults wrong");

  irq_line_a: assert property (@(posedge mclk) disable iff (rst)
    fault_irq_n |-> $past(next_pend) == 12'h0)
    else $error("interrupt high with a fault pending");

  irq_level_a: assert property (@(posedge mclk) disable iff (rst)
    (irq_status & irq_mask) != 12'h0 |=> irq)
    else $error("masked status did not raise irq");

  ldo_fault_a: assert property (@(posedge mclk) disable iff (rst)
    fault_now[11:4] != 8'h0 |=> !fault_irq_n)
    else $error("ldo fault did not assert the interrupt");

  write_resp_a: assert property (@(posedge mclk) disable iff (rst)
    do_write |=> s_bvalid)
    else $error("write not answered");

  code_write_a: assert property (@(posedge mclk) disable iff (rst)
    do_write && cur_word[32] && wreq.addr[7:5] == rcf_pkg::OFS_LDO_CODE[7:5]
      |=> ldo_reg[$past(wreq.addr[4:2])] == $past(wword[5:0]))
    else $error("ldo code register not written");

  status_set_a: assert property (@(posedge mclk) disable iff (rst)
    (next_pend & ~pend) != 12'h0 |=> (irq_status & $past(next_pend & ~pend))
      == $past(next_pend & ~pend))
    else $error("new fault lost from status");
endmodule : rcf_top

//--- rcf_rail_model.sv
// Rail model: power-good comparators of the bucks and LDOs
`timescale 1ns/1ps
module rcf_rail_model (
  input wire logic [3:0] buck_on,
  input wire logic [7:0] ldo_on,
  input wire logic [3:0] buck_fault,
  input wire logic [7:0] ldo_fault,
  output logic [3:0] buck_pg_in,
  output logic [7:0] ldo_pg_in
);
  // An off rail sits at ground, so it never reads as in regulation
  assign buck_pg_in = buck_on & ~buck_fault;
  assign ldo_pg_in = ldo_on & ~ldo_fault;
endmodule : rcf_rail_model

//--- testbench.sv
// Self-checking bench of the regulator control block
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0] s_awaddr, s_araddr, ldo_on, ldo_discharge, ldo_pg_in, ldo_fault;
  logic [31:0] s_wdata, s_rdata, v, rd;
  logic [3:0] s_wstrb, voltage_bank_pin, buck_pg_in, buck_on, buck_fault;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic fault_irq_n, irq;
  rcf_pkg::rcf_vcode_type [3:0] buck_code;
  rcf_pkg::rcf_vcode_type [7:0] ldo_code;
  logic [31:0] seed = 32'h8b1c;
  int bank0[4], bank1[4], lcode[8];
  int fails = 0;
  int tests_run = 0;
  int i;

  // Clock at 25 MHz
  always #20 mclk = ~mclk;

  rcf_top dut_u (.mclk, .rst, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
    .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp,
    .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
    .s_rresp, .voltage_bank_pin, .buck_pg_in, .ldo_pg_in, .buck_on,
    .buck_code, .ldo_on, .ldo_code, .ldo_discharge, .fault_irq_n, .irq);
  rcf_rail_model rail_u (.buck_on, .ldo_on, .buck_fault, .ldo_fault,
    .buck_pg_in, .ldo_pg_in);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic final_report();
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Bus tasks hold each request until its own ready, then wait the answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= d;
    s_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 40);
    check("write answer", 32'(n < 40), 32'h1);
    if (n >= 40) final_report();
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_write

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    s_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 40);
    check("read answer", 32'(n < 40), 32'h1);
    if (n >= 40) final_report();
    check(name, s_rdata, exp);
    check("rresp", {30'h0, s_rresp}, {30'h0, er});
    s_rready <= 1'b0;
  endtask : rdchk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    check("bresp", {30'h0, rsp}, {30'h0, rcf_pkg::RESP_OKAY});
  endtask : wr

  // Bounded wait for the fault line; a few cycles cover its latency
  task automatic wait_irq(input logic lvl, input string name);
    int n;
    n = 0;
    while (fault_irq_n !== lvl && n < 6) begin
      @(posedge mclk);
      n++;
    end
    check(name, {31'h0, fault_irq_n}, {31'h0, lvl});
    if (fault_irq_n !== lvl) final_report();
  endtask : wait_irq

  task automatic hold_irq(input logic lvl, input string name);
    repeat (8) begin
      @(posedge mclk);
      check(name, {31'h0, fault_irq_n}, {31'h0, lvl});
    end
  endtask : hold_irq

  // Main sequence
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {s_awaddr, s_araddr, s_wdata} = 48'h0;
    s_wstrb = 4'hf;
    voltage_bank_pin = 4'h0;
    buck_fault = 4'h0;
    ldo_fault = 8'h00;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      check("ldo code rst", {26'h0, ldo_code[i]},
        {26'h0, rcf_pkg::LDO_CODE_RST});
      if (i < 4) begin
        check("buck code rst", {26'h0, buck_code[i]},
          {26'h0, rcf_pkg::BUCK_CODE_RST});
      end
    end
    check("on rst", {20'h0, buck_on, ldo_on},
      {20'h0, rcf_pkg::BUCK_EN_RST, rcf_pkg::LDO_EN_RST});
    check("idle", {23'h0, ldo_discharge, fault_irq_n}, 32'h1);
    rdchk("buck ctrl rst", rcf_pkg::OFS_BUCK_CTRL, 32'hf, 2'h0);
    rdchk("pg rst", rcf_pkg::OFS_PG_STAT, 32'hfff, 2'h0);
    // Both code banks of every buck, then random bank pins
    for (i = 0; i < 4; i++) begin
      v = rnd();
      bank0[i] = v & 32'h3f;
      wr(rcf_pkg::OFS_BANK0 + 8'(4 * i), v);
      rdchk("bank0", rcf_pkg::OFS_BANK0 + 8'(4 * i), bank0[i], 2'h0);
      v = rnd();
      bank1[i] = v & 32'h3f;
      wr(rcf_pkg::OFS_BANK1 + 8'(4 * i), v);
      rdchk("bank1", rcf_pkg::OFS_BANK1 + 8'(4 * i), bank1[i], 2'h0);
    end
    repeat (6) begin
      @(posedge mclk);
      voltage_bank_pin <= 4'(rnd());
      repeat (3) @(posedge mclk);
      for (i = 0; i < 4; i++) begin
        v = voltage_bank_pin[i] ? bank1[i] : bank0[i];
        check("buck code", {26'h0, buck_code[i]}, v);
      end
    end
    // LDO codes
    for (i = 0; i < 8; i++) begin
      v = rnd();
      lcode[i] = v & 32'h3f;
      wr(rcf_pkg::OFS_LDO_CODE + 8'(4 * i), v);
    end
    // The code outputs trail the last register write by one cycle
    repeat (2) @(posedge mclk);
    for (i = 0; i < 8; i++) begin
      check("ldo code", {26'h0, ldo_code[i]}, lcode[i]);
      rdchk("ldo code rd", rcf_pkg::OFS_LDO_CODE + 8'(4 * i),
        lcode[i], 2'h0);
    end
    // Random enables and pulldowns; healthy rails raise no fault
    repeat (4) begin
      v = rnd();
      wr(rcf_pkg::OFS_BUCK_CTRL, v);
      rd = rnd();
      wr(rcf_pkg::OFS_LDO_CTRL, rd);
      repeat (2) @(posedge mclk);
      check("buck on", {28'h0, buck_on}, v & 32'hf);
      check("ldo on", {24'h0, ldo_on}, rd & 32'hff);
      check("discharge", {24'h0, ldo_discharge},
        {24'h0, rd[15:8] & ~rd[7:0]});
      rdchk("buck ctrl", rcf_pkg::OFS_BUCK_CTRL, v & 32'hf0f, 2'h0);
      rdchk("ldo ctrl", rcf_pkg::OFS_LDO_CTRL, rd & 32'hffffff, 2'h0);
    end
    // Buck 1 watched, buck 2 faulty but not watched
    wr(rcf_pkg::OFS_BUCK_CTRL, 32'h20f);
    wr(rcf_pkg::OFS_LDO_CTRL, 32'h2020ff);
    wr(rcf_pkg::OFS_IRQ_STAT, 32'hfff);
    wait_irq(1'b1, "irq idle");
    buck_fault <= 4'h4;
    hold_irq(1'b1, "unwatched fault");
    rdchk("silent", rcf_pkg::OFS_IRQ_STAT, 32'h0, 2'h0);
    buck_fault <= 4'h6;
    wait_irq(1'b0, "irq on buck fault");
    rdchk("pg faulty", rcf_pkg::OFS_PG_STAT, 32'hff9, 2'h0);
    hold_irq(1'b0, "held while faulty");
    buck_fault <= 4'h4;
    wait_irq(1'b1, "released");
    // Recovery alone does not release until the host reads
    buck_fault <= 4'h6;
    wait_irq(1'b0, "irq again");
    buck_fault <= 4'h4;
    hold_irq(1'b0, "held until read");
    rdchk("pg read", rcf_pkg::OFS_PG_STAT, 32'hffb, 2'h0);
    wait_irq(1'b1, "released by read");
    // LDO 5 fault, released by switching it off
    ldo_fault <= 8'h20;
    wait_irq(1'b0, "irq on ldo fault");
    rdchk("pg ldo", rcf_pkg::OFS_PG_STAT, 32'hdfb, 2'h0);
    wr(rcf_pkg::OFS_LDO_CTRL, 32'h2020df);
    wait_irq(1'b1, "released by off");
    check("discharge off", {24'h0, ldo_discharge}, 32'h20);
    // Status, mask and the level interrupt
    rdchk("irq status", rcf_pkg::OFS_IRQ_STAT, 32'h202, 2'h0);
    wr(rcf_pkg::OFS_IRQ_MASK, 32'h200);
    repeat (2) @(posedge mclk);
    check("irq masked in", {31'h0, irq}, 32'h1);
    wr(rcf_pkg::OFS_IRQ_STAT, 32'h200);
    repeat (2) @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdchk("irq status w1c", rcf_pkg::OFS_IRQ_STAT, 32'h2, 2'h0);
    // Unmapped place
    rdchk("unmapped", 8'h14, 32'h0, rcf_pkg::RESP_SLVERR);
    axi_write(8'h14, 32'h1, rsp);
    check("unmapped w", {30'h0, rsp}, {30'h0, rcf_pkg::RESP_SLVERR});
    final_report();
  end
endmodule : testbench
